// >>> bpf_pkg.sv
// Package with shared constants and types of the buffer pointer flow block.
package bpf_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;
	localparam logic [2:0] CMD_FIRST_START = 3'h0;
	localparam logic [2:0] CMD_FIRST_END = 3'h1;
	localparam logic [2:0] CMD_SECOND_START = 3'h2;
	localparam logic [2:0] CMD_SECOND_END = 3'h3;
	localparam logic [2:0] CMD_FLOW_MODE = 3'h4;
	localparam logic [2:0] CMD_FLAG_STATUS = 3'h5;
	localparam int FLOW_RELEASE_BIT = 4;
	localparam int FIRST_MODE_LSB = 0;
	localparam int SECOND_MODE_LSB = 2;
	localparam logic [1:0] MODE_CHAIN = 2'h0;
	localparam logic [1:0] MODE_STOP = 2'h1;
	localparam logic [15:0] ADDR_READ_PAD = 16'hE000;
	localparam logic [15:0] RESERVED_READ = 16'hFFFF;
	localparam logic [11:0] RESET_POINTER = 12'h000;
	localparam logic [11:0] RESET_FIRST_START = 12'h000;
	localparam logic [11:0] RESET_FIRST_END = 12'hFFF;
	localparam logic [11:0] RESET_SECOND_START = 12'h000;
	localparam logic [11:0] RESET_SECOND_END = 12'h000;
	localparam logic [3:0] RESET_FLOW_MODE = 4'h0;
	typedef enum logic [1:0] {
		BPF_HOST_IDLE = 2'b00,
		BPF_HOST_ACCESS = 2'b01,
		BPF_HOST_ANSWER = 2'b11
	} bpf_host_state_t;
endpackage : bpf_pkg

// >>> bpf_link_if.sv
// Interface joining the command port host and the buffer pointer device.
`timescale 1ns/10ps
interface bpf_link_if;
	logic command_select_n;
	logic chip_select_n;
	logic read_write;
	logic [2:0] command_select_lines;
	logic [15:0] host_data_out;
	logic host_data_oe;
	logic [15:0] device_data_out;
	logic device_data_oe;
	logic count_advance_enable_n;
	logic pointer_load_n;
	logic [11:0] pointer_load_value;
	logic jump_first_start_n;
	logic jump_second_start_n;
	logic first_buffer_end_flag_n;
	logic second_buffer_end_flag_n;
	logic [11:0] pointer;
	logic write_inhibit;
	modport device (
		input command_select_n, chip_select_n, read_write,
		input command_select_lines, host_data_out, host_data_oe,
		input count_advance_enable_n, pointer_load_n, pointer_load_value,
		input jump_first_start_n, jump_second_start_n,
		output device_data_out, device_data_oe,
		output first_buffer_end_flag_n, second_buffer_end_flag_n,
		output pointer, write_inhibit
	);
	modport host (
		output command_select_n, chip_select_n, read_write,
		output command_select_lines, host_data_out, host_data_oe,
		output count_advance_enable_n, pointer_load_n, pointer_load_value,
		output jump_first_start_n, jump_second_start_n,
		input device_data_out, device_data_oe,
		input first_buffer_end_flag_n, second_buffer_end_flag_n,
		input pointer, write_inhibit
	);
endinterface : bpf_link_if

// >>> bpf_host.sv
// Host end: turns software register accesses into command mode cycles.
`timescale 1ns/10ps
module bpf_host
	import bpf_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Link to the device.
	bpf_link_if.host link,
	// Software port.
	input wire logic [3:0] sw_addr,
	input wire logic [15:0] sw_wdata,
	input wire logic sw_write,
	input wire logic sw_read,
	output logic [15:0] sw_rdata,
	// Sequential side controls.
	input wire logic seq_count_n,
	input wire logic seq_load_n,
	input wire logic [11:0] seq_load_value,
	input wire logic seq_jump_first_n,
	input wire logic seq_jump_second_n
);
	// Software offsets 0 to 7 map to command codes; 8 reads the link status.
	localparam logic [3:0] SW_LINK_STATUS = 4'h8;
	logic release_pending;
	logic release_hold;

	// Clean the data driven by the host before it goes out.
	function automatic logic [15:0] host_wdata(input logic [2:0] code,
		input logic [15:0] d);
		logic [15:0] r;
		r = d;
		if (code <= CMD_SECOND_END)
			r[12] = 1'b0;
		if (code == CMD_FLOW_MODE) begin
			if (d[1]) r[1:0] = MODE_STOP;
			if (d[3]) r[3:2] = MODE_STOP;
		end
		return r;
	endfunction : host_wdata

	// Command access lasts one cycle; the answer is sampled the next.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			link.command_select_n <= 1'b1;
			link.chip_select_n <= 1'b1;
			link.read_write <= 1'b1;
			link.command_select_lines <= 3'h0;
			link.host_data_out <= 16'h0000;
			link.host_data_oe <= 1'b0;
		end else if (clk_en) begin
			link.chip_select_n <= 1'b1;
			link.command_select_n <= 1'b1;
			link.read_write <= 1'b1;
			link.host_data_oe <= 1'b0;
			if ((sw_write || sw_read) && !sw_addr[3]) begin
				link.command_select_n <= 1'b0;
				link.command_select_lines <= sw_addr[2:0];
				link.read_write <= !sw_write;
				link.host_data_oe <= sw_write;
				link.host_data_out <= host_wdata(sw_addr[2:0], sw_wdata);
			end
		end
	end

	// Read data for software is the device answer, one cycle later, or the link status for offset 8.
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			sw_rdata <= 16'h0000;
		else if (clk_en) begin
			if (sw_read && sw_addr == SW_LINK_STATUS)
				sw_rdata <= {12'h000, link.write_inhibit, 1'b0,
					!link.second_buffer_end_flag_n,
					!link.first_buffer_end_flag_n};
			else if (sw_read && !sw_addr[3])
				sw_rdata <= 16'h0000;
			else
				sw_rdata <= link.device_data_oe ? link.device_data_out
					: sw_rdata;
		end
	end

	// A release write forces count enable low on the next edge.
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			release_pending <= 1'b0;
		else if (clk_en)
			release_pending <= sw_write && sw_addr == {1'b0, CMD_FLOW_MODE}
				&& !sw_wdata[FLOW_RELEASE_BIT];
	end
	assign release_hold = release_pending;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			link.count_advance_enable_n <= 1'b1;
			link.pointer_load_n <= 1'b1;
			link.pointer_load_value <= 12'h000;
			link.jump_first_start_n <= 1'b1;
			link.jump_second_start_n <= 1'b1;
		end else if (clk_en) begin
			link.count_advance_enable_n <= seq_count_n && !release_hold;
			link.pointer_load_n <= seq_load_n;
			link.pointer_load_value <= seq_load_value;
			link.jump_first_start_n <= seq_jump_first_n;
			link.jump_second_start_n <= seq_jump_second_n;
		end
	end
endmodule : bpf_host

// >>> bpf_device.sv
// Device end: buffer registers, flow modes, flags and sequential pointer.
// What this block does
// - Address registers hold 12 bits, top bits read 1110.
// - Read/write control low writes, high reads.
// - Host selects register with command select lines.
// - Chaining: flag end, continue at other start.
// - Stop: flag end, stop at end or end+1.
// - Stopped pointer blocks sequential writes.
// - Bit 4 zero releases; next count gives end+2, or end+1 if stopped at end.
// - Load or start jumps also release.
// - Host holds count enable low after release.
// - Equal ends set both flags together.
// - Equal ends jump to first start.
// - Two-bit mode fields; codes 10, 11 reserved.
// - End flags are active-low outputs.
// - Flag status read: bit0 first, bit1 second.
// - Writing zero clears that flag.
// - Writing one keeps that flag.
// - Flag bits clear independently.
// - Host programs both buffers and modes.
// - Codes 000-011 select start/end registers.
// - Code 100 flow, 101 flags, rest reserved.
// - Reserved code reads all ones.
`timescale 1ns/10ps
module bpf_device
	import bpf_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Link to the host.
	bpf_link_if.device link
);
	logic [11:0] first_start;
	logic [11:0] first_end;
	logic [11:0] second_start;
	logic [11:0] second_end;
	logic [3:0] flow_mode;
	logic first_flag;
	logic second_flag;
	logic [11:0] pointer;
	logic stopped;
	logic stop_hit;
	logic released;
	logic load_pending;
	logic [11:0] load_reg;
	logic cmd_write;
	logic cmd_read;
	logic release_write;
	logic hit_first;
	logic hit_second;
	logic any_jump;
	logic [11:0] next_pointer;

	function automatic logic [15:0] addr_word(input logic [11:0] a);
		return ADDR_READ_PAD | {4'h0, a};
	endfunction : addr_word

	function automatic logic is_stop(input logic [1:0] m);
		return m == MODE_STOP;
	endfunction : is_stop

	assign cmd_write = !link.command_select_n && link.chip_select_n
		&& !link.read_write;
	assign cmd_read = !link.command_select_n && link.chip_select_n
		&& link.read_write;
	assign release_write = cmd_write
		&& link.command_select_lines == CMD_FLOW_MODE
		&& !link.host_data_out[FLOW_RELEASE_BIT];
	assign hit_first = pointer == first_end;
	assign hit_second = pointer == second_end;
	assign any_jump = !link.jump_first_start_n || !link.jump_second_start_n;
	assign stop_hit = (hit_first && is_stop(flow_mode[1:0]) && !hit_second)
		|| (hit_second && is_stop(flow_mode[3:2]) && !hit_first);

	// Buffer address registers.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			first_start <= RESET_FIRST_START;
			first_end <= RESET_FIRST_END;
			second_start <= RESET_SECOND_START;
			second_end <= RESET_SECOND_END;
		end else if (clk_en && cmd_write) begin
			unique case (link.command_select_lines)
				CMD_FIRST_START: first_start <= link.host_data_out[11:0];
				CMD_FIRST_END: first_end <= link.host_data_out[11:0];
				CMD_SECOND_START: second_start <= link.host_data_out[11:0];
				CMD_SECOND_END: second_end <= link.host_data_out[11:0];
				default: ;
			endcase
		end
	end

	// Flow modes; reserved codes are stored as written and act as chaining.
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			flow_mode <= RESET_FLOW_MODE;
		else if (clk_en && cmd_write
			&& link.command_select_lines == CMD_FLOW_MODE)
			flow_mode <= link.host_data_out[3:0];
	end

	// Flags: a match in the same cycle as a clear wins over the clear.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			first_flag <= 1'b0;
			second_flag <= 1'b0;
		end else if (clk_en) begin
			if (cmd_write && link.command_select_lines == CMD_FLAG_STATUS) begin
				if (!link.host_data_out[0]) first_flag <= 1'b0;
				if (!link.host_data_out[1]) second_flag <= 1'b0;
			end
			if (hit_first) first_flag <= 1'b1;
			if (hit_second) second_flag <= 1'b1;
		end
	end

	// Register read back, answered in the cycle after the strobe.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			link.device_data_out <= 16'h0000;
			link.device_data_oe <= 1'b0;
		end else if (clk_en) begin
			link.device_data_oe <= cmd_read;
			unique case (link.command_select_lines)
				CMD_FIRST_START: link.device_data_out <= addr_word(first_start);
				CMD_FIRST_END: link.device_data_out <= addr_word(first_end);
				CMD_SECOND_START: link.device_data_out <= addr_word(second_start);
				CMD_SECOND_END: link.device_data_out <= addr_word(second_end);
				CMD_FLOW_MODE: link.device_data_out <= {12'hFFE, flow_mode};
				CMD_FLAG_STATUS:
					link.device_data_out <= {14'h3FFF, second_flag, first_flag};
				default: link.device_data_out <= RESERVED_READ;
			endcase
		end
	end

	// Pointer load takes effect one cycle after the load is sampled.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			load_pending <= 1'b0;
			load_reg <= RESET_POINTER;
		end else if (clk_en) begin
			load_pending <= !link.pointer_load_n;
			if (!link.pointer_load_n) load_reg <= link.pointer_load_value;
		end
	end

	// Next pointer value for one counting edge.
	always_comb begin
		next_pointer = pointer + 12'h001;
		if (hit_first && hit_second)
			next_pointer = first_start;
		else if (hit_first && !is_stop(flow_mode[1:0]))
			next_pointer = second_start;
		else if (hit_second && !is_stop(flow_mode[3:2]))
			next_pointer = first_start;
	end

	// Stop handling. The release is taken on the sequential count after the command edge,
	// not on the command edge itself, which is why the host must force a count.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pointer <= RESET_POINTER;
			stopped <= 1'b0;
			released <= 1'b0;
		end else if (clk_en) begin
			if (load_pending || any_jump || release_write) begin
				stopped <= 1'b0;
				released <= release_write && stopped;
				if (load_pending) pointer <= load_reg;
				else if (!link.jump_first_start_n) pointer <= first_start;
				else if (!link.jump_second_start_n) pointer <= second_start;
			end else if (released) begin
				released <= 1'b0;
				if (!link.count_advance_enable_n)
					pointer <= pointer + 12'h001;
				else
					stopped <= 1'b1;
			end else if (!stopped && !link.pointer_load_n) begin
				pointer <= pointer;
			end else if (!stopped && stop_hit) begin
				// The edge after the match decides: a count there moves one past.
				stopped <= 1'b1;
				if (!link.count_advance_enable_n)
					pointer <= pointer + 12'h001;
			end else if (!stopped && !link.count_advance_enable_n) begin
				pointer <= next_pointer;
			end
		end
	end

	// Flag pins and write inhibit come from flip-flops.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			link.first_buffer_end_flag_n <= 1'b1;
			link.second_buffer_end_flag_n <= 1'b1;
			link.write_inhibit <= 1'b0;
			link.pointer <= RESET_POINTER;
		end else if (clk_en) begin
			link.first_buffer_end_flag_n <= !(first_flag || hit_first);
			link.second_buffer_end_flag_n <= !(second_flag || hit_second);
			link.write_inhibit <= stopped;
			link.pointer <= pointer;
		end
	end
endmodule : bpf_device

// >>> bpf_link_chk.sv
// Checker for the command link between the host and device ends.
`timescale 1ns/10ps
module bpf_link_chk (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Link signals.
	input wire logic command_select_n,
	input wire logic chip_select_n,
	input wire logic read_write,
	input wire logic [2:0] command_select_lines,
	input wire logic [15:0] host_data_out,
	input wire logic host_data_oe,
	input wire logic [15:0] device_data_out,
	input wire logic device_data_oe,
	input wire logic count_advance_enable_n,
	input wire logic write_inhibit
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence cmd_rd;
		!command_select_n && chip_select_n && read_write;
	endsequence
	sequence cmd_wr;
		!command_select_n && chip_select_n && !read_write && host_data_oe;
	endsequence
	// Only a release while stopped obliges the host to force a count.
	sequence rel_wr;
		write_inhibit ##0 cmd_wr ##0
			(command_select_lines == 3'h4 && !host_data_out[4]);
	endsequence
	a_chip_held: assert property (chip_select_n)
		else $error("chip select went active");
	a_read_answer: assert property (cmd_rd |=> device_data_oe)
		else $error("read got no answer");
	a_answer_cause: assert property (device_data_oe |->
		!$past(command_select_n) && $past(read_write))
		else $error("answer without read");
	a_reserved_ones: assert property (cmd_rd ##0
		command_select_lines[2:1] == 2'h3 |=> device_data_out == 16'hFFFF)
		else $error("reserved read not all ones");
	a_addr_pad: assert property (cmd_rd ##0 !command_select_lines[2]
		|=> device_data_out[15:12] == 4'hE)
		else $error("address read top bits wrong");
	a_host_bit12: assert property (cmd_wr ##0
		!command_select_lines[2] |-> !host_data_out[12])
		else $error("address write bit 12 high");
	a_release_count: assert property (rel_wr
		|-> ##[1:2] !count_advance_enable_n)
		else $error("count not forced after release");
	a_inhibit_drop: assert property (rel_wr |-> ##[1:2] !write_inhibit)
		else $error("release left writes blocked");
endmodule : bpf_link_chk

// >>> tb.sv
// Self-checking bench joining the host and device ends of the pointer block.
`timescale 1ns/10ps
module tb
	import bpf_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic [11:0] frozen_ptr;
	logic [3:0] sw_addr = 4'h0;
	logic [15:0] sw_wdata = 16'h0000;
	logic sw_write = 1'b0;
	logic sw_read = 1'b0;
	logic [15:0] sw_rdata;
	logic seq_count_n = 1'b1;
	logic seq_load_n = 1'b1;
	logic [11:0] seq_load_value = 12'h000;
	logic seq_jump_first_n = 1'b1;
	logic seq_jump_second_n = 1'b1;
	int num_errors = 0;
	int tests_run = 0;
	bpf_link_if link ();
	bpf_host bpf_host_i (.clk(clk), .reset(reset), .clk_en(clk_en),
		.link(link), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata),
		.seq_count_n(seq_count_n), .seq_load_n(seq_load_n),
		.seq_load_value(seq_load_value), .seq_jump_first_n(seq_jump_first_n),
		.seq_jump_second_n(seq_jump_second_n));
	bpf_device bpf_device_i (.clk(clk), .reset(reset), .clk_en(clk_en),
		.link(link));
	bpf_link_chk bpf_link_chk_i (.clk(clk), .reset(reset),
		.command_select_n(link.command_select_n),
		.chip_select_n(link.chip_select_n), .read_write(link.read_write),
		.command_select_lines(link.command_select_lines),
		.host_data_out(link.host_data_out), .host_data_oe(link.host_data_oe),
		.device_data_out(link.device_data_out),
		.device_data_oe(link.device_data_oe),
		.count_advance_enable_n(link.count_advance_enable_n),
		.write_inhibit(link.write_inhibit));
	always #4 clk = ~clk;
	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	task automatic check(input logic [15:0] got, exp, input string what);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask : check
	// The gap after a write keeps its bus cycle clear of the next answer.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_write <= 1'b1;
		@(posedge clk);
		sw_write <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
		@(posedge clk);
		sw_addr <= a;
		sw_read <= 1'b1;
		@(posedge clk);
		sw_read <= 1'b0;
		repeat (3) @(posedge clk);
		#1 check(sw_rdata & m, e, "read");
	endtask : rd
	task automatic wait_ptr(input logic [11:0] v);
		int n;
		n = 0;
		while (link.pointer !== v && n < 64) begin
			@(posedge clk);
			#1 n++;
		end
		check({4'h0, link.pointer}, {4'h0, v}, "pointer");
		if (n >= 64) begin
			final_report();
		end
	endtask : wait_ptr
	task automatic count(input logic on);
		@(posedge clk);
		seq_count_n <= !on;
	endtask : count
	task automatic t_reset();
		rd(4'h0, 16'hE000, 16'hFFFF);
		rd(4'h1, 16'hEFFF, 16'hFFFF);
		rd(4'h4, 16'hFFE0, 16'hFFFF);
		rd(4'h6, RESERVED_READ, 16'hFFFF);
		rd(4'h7, RESERVED_READ, 16'hFFFF);
	endtask : t_reset
	task automatic t_regs();
		for (int i = 0; i < 4; i++) begin
			wr(4'(i), 16'h1A50 + 16'(i));
			rd(4'(i), 16'hEA50 + 16'(i), 16'hFFFF);
		end
		wr(4'h0, 16'h0010);
		wr(4'h1, 16'h0013);
		wr(4'h2, 16'h0020);
		wr(4'h3, 16'h0022);
		wr(4'h4, 16'h0000);
	endtask : t_regs
	task automatic t_chain();
		@(posedge clk);
		seq_load_n <= 1'b0;
		seq_load_value <= 12'h010;
		@(posedge clk);
		seq_load_n <= 1'b1;
		wait_ptr(12'h010);
		count(1'b1);
		wait_ptr(12'h013);
		check(16'(link.first_buffer_end_flag_n), 16'h0, "flag");
		wait_ptr(12'h020);
		wait_ptr(12'h022);
		count(1'b0);
		rd(4'h5, 16'h0003, 16'h0003);
		wr(4'h5, 16'hFFFE);
		rd(4'h5, 16'h0002, 16'h0003);
		wr(4'h5, 16'hFFFD);
		rd(4'h5, 16'h0000, 16'h0003);
	endtask : t_chain
	// First buffer stops while the second still chains.
	task automatic t_stop();
		wr(4'h4, 16'h0001);
		@(posedge clk);
		seq_jump_first_n <= 1'b0;
		@(posedge clk);
		seq_jump_first_n <= 1'b1;
		wait_ptr(12'h010);
		count(1'b1);
		wait_ptr(12'h014);
		repeat (4) @(posedge clk);
		#1 check({4'h0, link.pointer}, 16'h0014, "stopped");
		check(16'(link.write_inhibit), 16'h1, "inhibit");
		wr(4'h4, 16'h0001);
		wait_ptr(12'h015);
		count(1'b0);
		check(16'(link.write_inhibit), 16'h0, "released");
	endtask : t_stop
	// Stop again, look at the link status, then release by a second jump.
	task automatic t_jump();
		count(1'b1);
		wait_ptr(12'h014);
		rd(4'h8, 16'h0008, 16'h0008);
		@(posedge clk);
		seq_jump_second_n <= 1'b0;
		@(posedge clk);
		seq_jump_second_n <= 1'b1;
		wait_ptr(12'h020);
		check(16'(link.write_inhibit), 16'h0, "jump release");
		count(1'b0);
	endtask : t_jump
	// A low clock enable must hold the pointer even while counting.
	task automatic t_freeze();
		count(1'b1);
		repeat (2) @(posedge clk);
		clk_en <= 1'b0;
		#1 frozen_ptr = link.pointer;
		repeat (4) @(posedge clk);
		#1 check({4'h0, link.pointer}, {4'h0, frozen_ptr}, "frozen");
		@(posedge clk);
		clk_en <= 1'b1;
		count(1'b0);
	endtask : t_freeze
	task automatic t_equal();
		wr(4'h4, 16'h0000);
		wr(4'h3, 16'h0013);
		wr(4'h5, 16'h0000);
		@(posedge clk);
		seq_jump_first_n <= 1'b0;
		@(posedge clk);
		seq_jump_first_n <= 1'b1;
		wait_ptr(12'h010);
		count(1'b1);
		wait_ptr(12'h013);
		check({15'h0, link.first_buffer_end_flag_n}, 16'h0, "f1");
		check({15'h0, link.second_buffer_end_flag_n}, 16'h0, "f2");
		wait_ptr(12'h010);
		count(1'b0);
	endtask : t_equal
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_regs();
		t_chain();
		t_stop();
		t_jump();
		t_freeze();
		t_equal();
		final_report();
	end
endmodule : tb
